// ---- design/baud_gen.sv ----
`timescale 1ns/1ps
module baud_gen #(
	parameter int DIV_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick
);
	logic [DIV_W-1:0] cnt_r;

	initial begin
		if (DIV_W < 1) $error("baud_gen: DIV_W must be at least 1");
	end

	// Held in reset while disabled so the first tick after enable is a full period
	always_ff @(posedge sys_clk) begin
		if (rst || !enable) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r >= divisor) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : baud_gen

// ---- design/shift_engine.sv ----
`timescale 1ns/1ps
module shift_engine (
	input wire logic sys_clk,
	input wire logic rst,
	shift_if.eng sif,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic ss_n
);
	typedef enum logic {ST_IDLE, ST_SHIFT} eng_state_t;
	eng_state_t state_r;
	logic [15:0] tx_sh_r;
	logic [15:0] rx_sh_r;
	logic [4:0] cnt_r;
	logic long_r;
	logic [4:0] last_bit;

	assign last_bit = long_r ? 5'(spi_buf_pkg::CHAR_LONG - 1) : 5'(spi_buf_pkg::CHAR_SHORT - 1);
	assign sif.busy = (state_r == ST_SHIFT);
	assign mosi = tx_sh_r[15];

	// Disable aborts any frame and parks the pins
	always_ff @(posedge sys_clk) begin
		if (rst || !sif.enable) begin
			state_r <= ST_IDLE;
			tx_sh_r <= '0;
			rx_sh_r <= '0;
			cnt_r <= '0;
			long_r <= 1'b0;
			sclk <= 1'b0;
			ss_n <= 1'b1;
			sif.done <= 1'b0;
			sif.rx_data <= '0;
		end else begin
			sif.done <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (sif.start) begin
						state_r <= ST_SHIFT;
						long_r <= sif.long_char;
						// Short characters are left aligned so mosi is always bit 15
						tx_sh_r <= sif.long_char ? sif.tx_data : {sif.tx_data[7:0], 8'h00};
						cnt_r <= '0;
						ss_n <= 1'b0;
					end
				end
				ST_SHIFT: begin
					if (sif.tick) begin
						sclk <= ~sclk;
						if (!sclk) begin
							rx_sh_r <= {rx_sh_r[14:0], miso};
						end else if (cnt_r == last_bit) begin
							state_r <= ST_IDLE;
							ss_n <= 1'b1;
							sif.done <= 1'b1;
							sif.rx_data <= long_r ? rx_sh_r : {8'h00, rx_sh_r[7:0]};
						end else begin
							cnt_r <= cnt_r + 5'h01;
							tx_sh_r <= {tx_sh_r[14:0], 1'b0};
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule : shift_engine

// ---- design/shift_if.sv ----
`timescale 1ns/1ps
interface shift_if;
	logic start;
	logic long_char;
	logic [15:0] tx_data;
	logic enable;
	logic tick;
	logic busy;
	logic done;
	logic [15:0] rx_data;

	modport ctrl (
		output start,
		output long_char,
		output tx_data,
		output enable,
		output tick,
		input busy,
		input done,
		input rx_data
	);
	modport eng (
		input start,
		input long_char,
		input tx_data,
		input enable,
		input tick,
		output busy,
		output done,
		output rx_data
	);
endinterface : shift_if

// ---- design/spi_buf_pkg.sv ----
package spi_buf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_CTRL = 3'h1;
	localparam logic [2:0] IDX_CFG = 3'h2;
	localparam logic [2:0] IDX_BAUD = 3'h3;
	localparam logic [2:0] IDX_ISTAT = 3'h4;
	localparam logic [2:0] IDX_IMASK = 3'h5;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 12;

	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h03;

	// Control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_MSTM = 1;
	localparam int CTRL_MODFE = 2;
	localparam int CTRL_MODF = 3;
	localparam int CTRL_WRITE_COLLISION_FLAG = 4;
	localparam int CTRL_ROVR = 5;
	localparam int CTRL_DONE = 6;
	localparam int CTRL_BUSY = 7;
	localparam logic [7:0] CTRL_SW_MASK = 8'h7f;

	// Configuration register field
	localparam int CFG_CHR = 2;
	localparam logic [7:0] CFG_SW_MASK = 8'h04;

	// Interrupt status / mask fields
	localparam int IRQ_W = 3;
	localparam int IRQ_WRITE_COLLISION_FLAG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_ROVR = 2;

	localparam int CHAR_SHORT = 8;
	localparam int CHAR_LONG = 16;
endpackage : spi_buf_pkg

// ---- design/spi_data_buffer_and_enable.sv ----
`timescale 1ns/1ps
module spi_data_buffer_and_enable #(
	parameter int DIV_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic ss_n,
	output logic irq
);
	shift_if sif ();

	logic [15:0] tx_buf_r;
	logic [15:0] rx_buf_r;
	logic rx_unread_r;
	logic [7:0] ctrl_r;
	// Software-held control bits; bit 7 is assembled from the engine
	logic [6:0] ctrl_sw_r;
	logic [7:0] cfg_r;
	logic [DIV_W-1:0] baud_r;
	logic [spi_buf_pkg::IRQ_W-1:0] istat_r;
	logic [spi_buf_pkg::IRQ_W-1:0] imask_r;
	logic start_r;

	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic [2:0] idx;
	logic mapped;
	logic idx_hit_lo;
	logic data_wr;
	logic collide;
	logic overrun;
	logic [31:0] rd_mux;
	logic [spi_buf_pkg::IRQ_W-1:0] events;

	initial begin
		if (DIV_W < 1 || DIV_W > 8) $error("spi_data_buffer_and_enable: DIV_W must be 1..8");
	end

	// APB decode
	assign idx = paddr[spi_buf_pkg::ADDR_LSB +: 3];
	assign idx_hit_lo = (paddr[spi_buf_pkg::ADDR_LSB-1:0] == '0)
		&& (paddr[spi_buf_pkg::ADDR_W-1:spi_buf_pkg::ADDR_LSB+3] == '0);
	assign mapped = idx_hit_lo && (idx <= spi_buf_pkg::IDX_IMASK);
	assign setup_ph = psel && !penable;
	// Zero wait states: the access phase always completes at its first edge
	assign pready = psel && penable;
	assign wr_acc = psel && penable && pwrite && mapped;
	assign rd_acc = psel && penable && !pwrite && mapped;

	assign data_wr = wr_acc && (idx == spi_buf_pkg::IDX_DATA);
	assign collide = data_wr && sif.busy;
	assign overrun = sif.done && rx_unread_r;
	assign events[spi_buf_pkg::IRQ_WRITE_COLLISION_FLAG] = collide;
	assign events[spi_buf_pkg::IRQ_DONE] = sif.done;
	assign events[spi_buf_pkg::IRQ_ROVR] = overrun;

	// Link to the engine
	assign sif.enable = ctrl_r[spi_buf_pkg::CTRL_EN];
	assign sif.long_char = cfg_r[spi_buf_pkg::CFG_CHR];
	assign sif.tx_data = tx_buf_r;
	assign sif.start = start_r;

	baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(ctrl_r[spi_buf_pkg::CTRL_EN]),
		.divisor(baud_r),
		.tick(sif.tick)
	);

	shift_engine u_eng (
		.sys_clk(sys_clk),
		.rst(rst),
		.sif(sif),
		.miso(miso),
		.sclk(sclk),
		.mosi(mosi),
		.ss_n(ss_n)
	);

	// Transmit buffer; writes blocked only while a frame shifts
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_buf_r <= spi_buf_pkg::DATA_RESET;
		end else if (data_wr && !sif.busy) begin
			if (pstrb[0]) tx_buf_r[7:0] <= pwdata[7:0];
			if (pstrb[1]) tx_buf_r[15:8] <= pwdata[15:8];
		end
	end

	// Start strobe: one cycle after an accepted write, only while enabled.
	// A write while disabled just loads the buffer; it is not replayed later.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			start_r <= 1'b0;
		end else begin
			start_r <= data_wr && !sif.busy && ctrl_r[spi_buf_pkg::CTRL_EN];
		end
	end

	// Receive buffer; on overrun the newer character is dropped
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_buf_r <= spi_buf_pkg::DATA_RESET;
		end else if (sif.done && !rx_unread_r) begin
			rx_buf_r <= sif.rx_data;
		end
	end

	// Unread marker; a new character wins over a simultaneous read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_unread_r <= 1'b0;
		end else if (sif.done) begin
			rx_unread_r <= 1'b1;
		end else if (rd_acc && idx == spi_buf_pkg::IDX_DATA) begin
			rx_unread_r <= 1'b0;
		end
	end

	// Control register: software bits, then hardware sets that win over clears
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_sw_r <= spi_buf_pkg::CTRL_RESET[6:0];
		end else begin
			if (wr_acc && idx == spi_buf_pkg::IDX_CTRL && pstrb[0]) begin
				ctrl_sw_r <= pwdata[6:0] & spi_buf_pkg::CTRL_SW_MASK[6:0];
			end
			if (collide) begin
				ctrl_sw_r[spi_buf_pkg::CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
			end
			if (overrun) begin
				ctrl_sw_r[spi_buf_pkg::CTRL_ROVR] <= 1'b1;
			end
			if (sif.done) begin
				ctrl_sw_r[spi_buf_pkg::CTRL_DONE] <= 1'b1;
			end
		end
	end

	// Top control bit mirrors the engine and ignores writes
	assign ctrl_r = {sif.busy, ctrl_sw_r};

	// Configuration: only the length select is implemented
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_r <= spi_buf_pkg::CFG_RESET;
		end else if (wr_acc && idx == spi_buf_pkg::IDX_CFG && pstrb[0]) begin
			cfg_r <= pwdata[7:0] & spi_buf_pkg::CFG_SW_MASK;
		end
	end

	// Baud divisor; a change takes effect at once in the generator's compare
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			baud_r <= spi_buf_pkg::BAUD_RESET[DIV_W-1:0];
		end else if (wr_acc && idx == spi_buf_pkg::IDX_BAUD && pstrb[0]) begin
			baud_r <= pwdata[DIV_W-1:0];
		end
	end

	// Interrupt status: write one to clear, a new event wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			istat_r <= '0;
		end else if (wr_acc && idx == spi_buf_pkg::IDX_ISTAT && pstrb[0]) begin
			istat_r <= (istat_r & ~pwdata[spi_buf_pkg::IRQ_W-1:0]) | events;
		end else begin
			istat_r <= istat_r | events;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			imask_r <= '0;
		end else if (wr_acc && idx == spi_buf_pkg::IDX_IMASK && pstrb[0]) begin
			imask_r <= pwdata[spi_buf_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((istat_r | events) & imask_r);
		end
	end

	// Read mux, sampled in the setup phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			spi_buf_pkg::IDX_DATA: rd_mux[15:0] = rx_buf_r;
			spi_buf_pkg::IDX_CTRL: rd_mux[7:0] = ctrl_r;
			spi_buf_pkg::IDX_CFG: rd_mux[7:0] = cfg_r;
			spi_buf_pkg::IDX_BAUD: rd_mux[DIV_W-1:0] = baud_r;
			spi_buf_pkg::IDX_ISTAT: rd_mux[spi_buf_pkg::IRQ_W-1:0] = istat_r;
			spi_buf_pkg::IDX_IMASK: rd_mux[spi_buf_pkg::IRQ_W-1:0] = imask_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Registered read data and error; unmapped addresses answer with pslverr
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr <= !mapped;
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end
endmodule : spi_data_buffer_and_enable

// ---- sim/spi_buf_monitor.sv ----
`timescale 1ns/1ps
module spi_buf_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic irq
);
	logic sclk_q;
	logic [4:0] rises_r;
	always_ff @(posedge sys_clk) begin
		sclk_q <= sclk;
	end
	// Rise seen one cycle late, still before the frame closes
	always_ff @(posedge sys_clk) begin
		if (rst || ss_n) begin
			rises_r <= 5'h00;
		end else if (sclk && !sclk_q) begin
			rises_r <= rises_r + 5'h01;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence frame_open;
		$fell(ss_n);
	endsequence
	sequence frame_held;
		!ss_n [*8];
	endsequence
	AST_READY: assert property (pready == (psel && penable))
		else $error("pready does not follow the access phase");
	AST_RESET_OUT: assert property ($fell(rst) |-> ss_n && !sclk && !irq && prdata == 32'h0)
		else $error("outputs not cleared by reset");
	AST_BUSY_HOLD: assert property (frame_open |-> frame_held)
		else $error("frame ended too soon");
	AST_SCLK_IN_FRAME: assert property ($changed(sclk) |-> !$past(ss_n))
		else $error("serial clock moved outside a frame");
	AST_IDLE_LOW: assert property (ss_n |-> !sclk)
		else $error("serial clock not idle");
	AST_FRAME_BITS: assert property ($rose(ss_n) |-> rises_r == 5'h08 || rises_r == 5'h10)
		else $error("frame length is neither 8 nor 16");
	AST_MOSI_STEADY: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi changed while clock high");
	AST_UNMAPPED: assert property (psel && penable && paddr[4:2] > 3'h5 |-> pslverr)
		else $error("unmapped access not refused");
endmodule : spi_buf_monitor

bind spi_data_buffer_and_enable spi_buf_monitor mon (.sys_clk, .rst, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .sclk, .mosi, .ss_n, .irq);

// ---- sim/spi_data_buffer_and_enable_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module spi_data_buffer_and_enable_bench;
	logic sys_clk;
	logic rst;
	logic psel, penable, pwrite, miso, pready, pslverr, sclk, mosi, ss_n, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [15:0] reply;
	int n_mismatch = 0;
	int n_tests = 0;
	spi_data_buffer_and_enable uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.miso(miso), .sclk(sclk), .mosi(mosi), .ss_n(ss_n), .irq(irq));
	spi_far_end far (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .reply(reply), .miso(miso));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [2:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {7'h00, idx, 2'h0};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [2:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		`CHK(q, e)
	endtask : rd
	task automatic wait_ss(input logic v);
		for (int i = 0; i < 400 && ss_n !== v; i++) @(posedge sys_clk);
		`CHK(ss_n, v)
	endtask : wait_ss
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, pstrb, reply} = {4'h8, 12'h0, 32'h0, 4'hf, 16'h0};
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(spi_buf_pkg::IDX_DATA, 32'h0);
		rd(spi_buf_pkg::IDX_CTRL, 32'h0);
		apb(1'b1, spi_buf_pkg::IDX_CTRL, 32'hff);
		rd(spi_buf_pkg::IDX_CTRL, 32'h7f);
		apb(1'b1, spi_buf_pkg::IDX_CTRL, 32'h0e);
		rd(spi_buf_pkg::IDX_CTRL, 32'h0e);
		apb(1'b1, spi_buf_pkg::IDX_IMASK, 32'h1);
		apb(1'b1, spi_buf_pkg::IDX_CTRL, 32'h1);
		reply = 16'hc300;
		apb(1'b1, spi_buf_pkg::IDX_DATA, 32'ha5);
		wait_ss(1'b0);
		rd(spi_buf_pkg::IDX_DATA, 32'h0);
		rd(spi_buf_pkg::IDX_CTRL, 32'h81);
		apb(1'b1, spi_buf_pkg::IDX_DATA, 32'h33);
		rd(spi_buf_pkg::IDX_CTRL, 32'h91);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b1)
		wait_ss(1'b1);
		`CHK(far.got_r, 16'h00a5)
		`CHK(far.bits_r, 5'h08)
		rd(spi_buf_pkg::IDX_CTRL, 32'h51);
		rd(spi_buf_pkg::IDX_DATA, 32'hc3);
		rd(spi_buf_pkg::IDX_ISTAT, 32'h3);
		// Completion stays pending but masked, so irq must drop
		apb(1'b1, spi_buf_pkg::IDX_ISTAT, 32'h1);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		apb(1'b1, spi_buf_pkg::IDX_CTRL, 32'h1);
		apb(1'b1, spi_buf_pkg::IDX_CFG, 32'h4);
		reply = 16'h9c3a;
		apb(1'b1, spi_buf_pkg::IDX_DATA, 32'h1234);
		wait_ss(1'b0);
		wait_ss(1'b1);
		`CHK(far.got_r, 16'h1234)
		`CHK(far.bits_r, 5'h10)
		rd(spi_buf_pkg::IDX_DATA, 32'h9c3a);
		apb(1'b1, spi_buf_pkg::IDX_CTRL, 32'h0);
		apb(1'b1, spi_buf_pkg::IDX_DATA, 32'h77);
		repeat (100) @(posedge sys_clk);
		`CHK(ss_n, 1'b1)
		rd(spi_buf_pkg::IDX_CTRL, 32'h0);
		apb(1'b0, 3'h6, 32'h0);
		`CHK(err, 1'b1)
		conclude();
	end
endmodule : spi_data_buffer_and_enable_bench

// ---- sim/spi_far_end.sv ----
`timescale 1ns/1ps
module spi_far_end (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic [15:0] reply,
	output logic miso
);
	logic [15:0] out_r;
	logic [15:0] got_r;
	logic [4:0] bits_r;
	logic last_r = 1'b0;
	// Released line shows the inverse so a stale bit cannot pass
	assign miso = ss_n ? ~last_r : out_r[15];
	always @(negedge ss_n) begin
		out_r = reply;
		got_r = 16'h0000;
		bits_r = 5'h00;
	end
	always @(posedge sclk) begin
		got_r = {got_r[14:0], mosi};
		bits_r = bits_r + 5'h01;
		last_r = out_r[15];
	end
	always @(negedge sclk) begin
		out_r = {out_r[14:0], 1'b0};
	end
endmodule : spi_far_end
